// ===== logic/tape_serializer_regs.svh
`ifndef TAPE_SERIALIZER_REGS_SVH
`define TAPE_SERIALIZER_REGS_SVH

// ------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define CTRL_OFS 4'h0
`define WRITE_BYTE_OFS 4'h4
`define READ_BYTE_OFS 4'h8
`define STATUS_OFS 4'hC

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CTRL_DIR_BIT 0
`define CTRL_WGATE_BIT 1
`define CTRL_MARK_BIT 2
`define CTRL_IRQEN_BIT 3
`define CTRL_RST 4'h0

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define STAT_TIMER_BIT 0
`define STAT_WAVE_BIT 1
`define STAT_DONE_BIT 2
`define STAT_SEQ_BIT 3

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define WRITE_BYTE_RST 8'h00
`define SHIFT_RST 8'hFF
`define SYS_PERIOD_NS 4
`define SYS_MHZ 250
`define TIMER_US 40
`define TIMER_CYCLES (`TIMER_US * `SYS_MHZ)
`define STROBE_NS 100
`define STROBE_CYCLES ((`STROBE_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)

`endif

// ===== logic/tape_serializer_pkg.sv
package tape_serializer_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [31:0] word_t;
   typedef logic [13:0] timer_count_t;
   typedef logic [4:0] strobe_count_t;
   // register selected by a bus access
   typedef enum {SEL_CTRL, SEL_WRITE_BYTE, SEL_READ_BYTE, SEL_STATUS, SEL_NONE} reg_sel_t;
endpackage : tape_serializer_pkg

// ===== logic/tape_write_read_serializer.sv
`timescale 1ns/1ps
`include "tape_serializer_regs.svh"

module tape_write_read_serializer #(
   parameter int TIMER_CYCLES = `TIMER_CYCLES
) (
   // clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RST_B,
   // avalon-mm slave
   input wire logic [3:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   // head side pins
   input wire logic I_WRITE_BIT_CLOCK,
   input wire logic I_READ_CLOCK,
   input wire logic I_READ_DATA,
   output logic O_WRITE_CLOCK,
   output logic O_WRITE_DATA,
   output logic O_WRITE_WAVEFORM,
   // processor side pins
   output logic O_TIMER_STROBE_B,
   output logic O_IRQ_OUT_SECOND_B
);

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // word-aligned decode; low address bits are ignored
   function automatic tape_serializer_pkg::reg_sel_t decode(input logic [3:0] addr);
      unique case ({addr[3:2], 2'h0})
         `CTRL_OFS: decode = tape_serializer_pkg::SEL_CTRL;
         `WRITE_BYTE_OFS: decode = tape_serializer_pkg::SEL_WRITE_BYTE;
         `READ_BYTE_OFS: decode = tape_serializer_pkg::SEL_READ_BYTE;
         `STATUS_OFS: decode = tape_serializer_pkg::SEL_STATUS;
         default: decode = tape_serializer_pkg::SEL_NONE;
      endcase
   endfunction : decode

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [1:0] bit_clk_sync;
   logic [1:0] rd_clk_sync;
   logic [1:0] rd_data_sync;
   logic bit_clk_last;
   logic rd_clk_last;

   // two flops per pin; only stage 1 is read downstream
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         bit_clk_sync <= 2'b00;
         rd_clk_sync <= 2'b00;
         rd_data_sync <= 2'b00;
         bit_clk_last <= 1'b0;
         rd_clk_last <= 1'b0;
      end else begin
         bit_clk_sync <= {bit_clk_sync[0], I_WRITE_BIT_CLOCK};
         rd_clk_sync <= {rd_clk_sync[0], I_READ_CLOCK};
         rd_data_sync <= {rd_data_sync[0], I_READ_DATA};
         bit_clk_last <= bit_clk_sync[1];
         rd_clk_last <= rd_clk_sync[1];
      end
   end

   logic bit_rise;
   logic bit_fall;
   logic rd_rise;
   assign bit_rise = bit_clk_sync[1] & ~bit_clk_last;
   assign bit_fall = ~bit_clk_sync[1] & bit_clk_last;
   assign rd_rise = rd_clk_sync[1] & ~rd_clk_last;

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   logic [3:0] ctrl;
   tape_serializer_pkg::byte_t write_byte;
   tape_serializer_pkg::byte_t shared_sr;
   tape_serializer_pkg::byte_t write_sr;
   logic waveform;
   logic seq_n;
   logic byte_done;
   logic timer_out;
   logic req;
   logic done;
   logic be_ok;
   tape_serializer_pkg::reg_sel_t sel;

   assign req = I_AVS_READ | I_AVS_WRITE;
   assign done = req & ~O_AVS_WAITREQUEST;
   assign sel = decode(I_AVS_ADDRESS);
   assign be_ok = I_AVS_BYTEENABLE[0];

   // one wait cycle per access; read data captured with the drop
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_AVS_WAITREQUEST <= 1'b1;
         O_AVS_READDATA <= 32'h0000_0000;
      end else begin
         O_AVS_WAITREQUEST <= ~(req & O_AVS_WAITREQUEST);
         if (I_AVS_READ && O_AVS_WAITREQUEST) begin
            unique case (sel)
               tape_serializer_pkg::SEL_CTRL: O_AVS_READDATA <= {28'h0000000, ctrl};
               tape_serializer_pkg::SEL_WRITE_BYTE: O_AVS_READDATA <= {24'h000000, write_byte};
               tape_serializer_pkg::SEL_READ_BYTE: O_AVS_READDATA <= {24'h000000, shared_sr};
               tape_serializer_pkg::SEL_STATUS:
                  O_AVS_READDATA <= {28'h0000000, seq_n, byte_done, waveform, timer_out};
               tape_serializer_pkg::SEL_NONE: O_AVS_READDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   // control register: direction, gate enable, mark generate, irq enable
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ctrl <= `CTRL_RST;
      end else if (done && I_AVS_WRITE && sel == tape_serializer_pkg::SEL_CTRL && be_ok) begin
         ctrl <= I_AVS_WRITEDATA[3:0];
      end
   end

   // write byte port
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         write_byte <= `WRITE_BYTE_RST;
      end else if (done && I_AVS_WRITE && sel == tape_serializer_pkg::SEL_WRITE_BYTE
                   && be_ok) begin
         write_byte <= I_AVS_WRITEDATA[7:0];
      end
   end

   logic dir_write;
   logic wgate;
   logic mark_generate;
   logic irq_en;
   assign dir_write = ctrl[`CTRL_DIR_BIT];
   assign wgate = ctrl[`CTRL_WGATE_BIT];
   assign mark_generate = ctrl[`CTRL_MARK_BIT];
   assign irq_en = ctrl[`CTRL_IRQEN_BIT];

   // ------------------------------------------------------------
   // write control sequencer
   // ------------------------------------------------------------
   logic wr_step;
   logic [7:0] next_shared_sr;
   assign wr_step = dir_write & bit_rise;
   assign next_shared_sr = {shared_sr[6:0], waveform};

   // sequence flop: low for one bit pulse to start each cycle
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         seq_n <= 1'b1;
      end else if (wr_step) begin
         if (!seq_n) begin
            seq_n <= 1'b1;
         end else if (!waveform && wgate) begin
            seq_n <= 1'b0;
         end
      end
   end

   // waveform flop: set on second pulse, cleared by last stage one
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         waveform <= 1'b0;
      end else if (wr_step) begin
         if (!seq_n) begin
            waveform <= 1'b1;
         end else if (waveform) begin
            waveform <= ~next_shared_sr[7];
         end
      end
   end

   // shared register: read deserializer or bit counter in write mode
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         shared_sr <= `SHIFT_RST;
      end else if (dir_write) begin
         if (wr_step) begin
            if (!seq_n) begin
               shared_sr <= 8'h00;
            end else if (!waveform && wgate) begin
               shared_sr <= 8'h00;
            end else if (waveform) begin
               shared_sr <= next_shared_sr;
            end
         end
      end else if (rd_rise) begin
         shared_sr <= {shared_sr[6:0], rd_data_sync[1]};
      end
   end

   // ------------------------------------------------------------
   // write shifter and output gating
   // ------------------------------------------------------------
   logic shift_clk;
   logic data_clk;
   assign shift_clk = wr_step & waveform;

   // load while waveform low; shift at the bit fall so data is steady at each clock rise
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         write_sr <= `WRITE_BYTE_RST;
      end else if (!waveform) begin
         write_sr <= write_byte;
      end else if (bit_fall && data_clk) begin
         write_sr <= {write_sr[6:0], 1'b0};
      end
   end

   // serial data: msb first, held low while marks are written
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_WRITE_DATA <= 1'b0;
      end else begin
         O_WRITE_DATA <= write_sr[7] & ~mark_generate;
      end
   end

   // data clock high from a gated bit rise to the bit fall
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         data_clk <= 1'b0;
      end else if (shift_clk) begin
         data_clk <= 1'b1;
      end else if (bit_fall || !dir_write) begin
         data_clk <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // timer strobe and one-shot
   // ------------------------------------------------------------
   tape_serializer_pkg::strobe_count_t strobe_cnt;
   tape_serializer_pkg::timer_count_t timer_cnt;
   logic strobe_start;
   assign strobe_start = done & I_AVS_READ & (sel == tape_serializer_pkg::SEL_READ_BYTE);

   // strobe rests high; each read byte access lowers it briefly
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         strobe_cnt <= 5'h00;
         O_TIMER_STROBE_B <= 1'b1;
      end else if (strobe_start) begin
         strobe_cnt <= 5'(`STROBE_CYCLES - 1);
         O_TIMER_STROBE_B <= 1'b0;
      end else if (strobe_cnt != 5'h00) begin
         strobe_cnt <= strobe_cnt - 5'h01;
      end else begin
         O_TIMER_STROBE_B <= 1'b1;
      end
   end

   // one-shot retriggers on each strobe, then counts out
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         timer_cnt <= 14'h0000;
         timer_out <= 1'b0;
      end else if (!O_TIMER_STROBE_B) begin
         timer_cnt <= 14'(TIMER_CYCLES - 1);
         timer_out <= 1'b1;
      end else if (timer_cnt != 14'h0000) begin
         timer_cnt <= timer_cnt - 14'h0001;
      end else begin
         timer_out <= 1'b0;
      end
   end

   // write clock: data clock, or strobe only while marks are written
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_WRITE_CLOCK <= 1'b0;
      end else begin
         O_WRITE_CLOCK <= data_clk | (mark_generate & ~O_TIMER_STROBE_B);
      end
   end

   // ------------------------------------------------------------
   // byte done flag and interrupt request
   // ------------------------------------------------------------
   logic wave_last;
   logic wave_fall;
   logic done_clear;
   assign wave_fall = wave_last & ~waveform;
   assign done_clear = done & I_AVS_WRITE & be_ok & (sel == tape_serializer_pkg::SEL_WRITE_BYTE);

   // a fall in the same cycle as the clear keeps the flag set
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         wave_last <= 1'b0;
         byte_done <= 1'b0;
      end else begin
         wave_last <= waveform;
         if (wave_fall) begin
            byte_done <= 1'b1;
         end else if (done_clear) begin
            byte_done <= 1'b0;
         end
      end
   end

   // active-low request while the flag is set and enabled
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         O_IRQ_OUT_SECOND_B <= 1'b1;
         O_WRITE_WAVEFORM <= 1'b0;
      end else begin
         O_IRQ_OUT_SECOND_B <= ~(byte_done & irq_en);
         O_WRITE_WAVEFORM <= waveform;
      end
   end

endmodule : tape_write_read_serializer

// ===== tb/tape_serializer_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module tape_serializer_asserts #(
   parameter int TIMER_CYCLES = 50
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RST_B,
   input wire logic [3:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   input wire logic [31:0] O_AVS_READDATA,
   input wire logic O_AVS_WAITREQUEST,
   input wire logic I_WRITE_BIT_CLOCK,
   input wire logic I_READ_CLOCK,
   input wire logic I_READ_DATA,
   input wire logic O_WRITE_CLOCK,
   input wire logic O_WRITE_DATA,
   input wire logic O_WRITE_WAVEFORM,
   input wire logic O_TIMER_STROBE_B,
   input wire logic O_IRQ_OUT_SECOND_B
);
   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (!I_RST_B);
   logic bclk_q, wave_q, cyc;
   logic [3:0] rises;
   logic [4:0] s_cnt;
   // pin rises per waveform phase; our edge detect leads the design's synchroniser
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         bclk_q <= 1'h0;
         wave_q <= 1'h0;
         rises <= 4'h0;
         cyc <= 1'h0;
      end else begin
         bclk_q <= I_WRITE_BIT_CLOCK;
         wave_q <= O_WRITE_WAVEFORM;
         rises <= (O_WRITE_WAVEFORM ^ wave_q) ? 4'h0 : rises + {3'h0, I_WRITE_BIT_CLOCK & ~bclk_q};
         cyc <= (wave_q & ~O_WRITE_WAVEFORM) ? 1'h1 : (rises > 4'h2 ? 1'h0 : cyc);
      end
   end
   // strobe low time, cleared while it rests high
   always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         s_cnt <= 5'h00;
      end else begin
         s_cnt <= O_TIMER_STROBE_B ? 5'h00 : s_cnt + 5'h01;
      end
   end
   property p_ack; (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST; endproperty
   a_ack: assert property (p_ack) else $error("bus answer late");
   property p_ack_one; !O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST; endproperty
   a_ack_one: assert property (p_ack_one) else $error("waitrequest low too long");
   property p_high_eight; $fell(O_WRITE_WAVEFORM) |-> rises == 4'h8; endproperty
   a_high_eight: assert property (p_high_eight) else $error("waveform high count wrong");
   property p_gap_two; $rose(O_WRITE_WAVEFORM) && cyc |-> rises == 4'h2; endproperty
   a_gap_two: assert property (p_gap_two) else $error("gap pulse count wrong");
   property p_gate; $rose(O_WRITE_CLOCK) |-> O_WRITE_WAVEFORM || $past(O_WRITE_WAVEFORM) ||
      !$past(O_TIMER_STROBE_B); endproperty
   a_gate: assert property (p_gate) else $error("write clock not gated");
   property p_strobe_cause; $fell(O_TIMER_STROBE_B) |-> $past(I_AVS_READ && !O_AVS_WAITREQUEST
      && I_AVS_ADDRESS[3:2] == 2'h2); endproperty
   a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without read");
   property p_strobe_width; $rose(O_TIMER_STROBE_B) |-> s_cnt == 5'h19; endproperty
   a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
   property p_irq; $fell(O_IRQ_OUT_SECOND_B) |-> $past(O_WRITE_WAVEFORM, 2) &&
      !$past(O_WRITE_WAVEFORM); endproperty
   a_irq: assert property (p_irq) else $error("irq not from waveform fall");
endmodule : tape_serializer_asserts

bind tape_write_read_serializer tape_serializer_asserts #(.TIMER_CYCLES(TIMER_CYCLES))
   i_tape_serializer_asserts (.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B),
   .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
   .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
   .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
   .I_WRITE_BIT_CLOCK(I_WRITE_BIT_CLOCK), .I_READ_CLOCK(I_READ_CLOCK),
   .I_READ_DATA(I_READ_DATA), .O_WRITE_CLOCK(O_WRITE_CLOCK), .O_WRITE_DATA(O_WRITE_DATA),
   .O_WRITE_WAVEFORM(O_WRITE_WAVEFORM), .O_TIMER_STROBE_B(O_TIMER_STROBE_B),
   .O_IRQ_OUT_SECOND_B(O_IRQ_OUT_SECOND_B));

// ===== tb/tape_head_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// head circuitry model
// ------------------------------------------------------------
module tape_head_model (
   // bench control
   input wire logic i_run,
   input wire logic i_rd_go,
   input wire logic [7:0] i_rd_byte,
   // head pins
   input wire logic i_wr_clk,
   input wire logic i_wr_data,
   output logic o_bit_clk,
   output logic o_rd_clk,
   output logic o_rd_data,
   output logic [7:0] o_wr_byte
);
   // bit clock stands low while the tape is not writing
   initial begin
      o_bit_clk = 1'h0;
      o_rd_clk = 1'h0;
      o_rd_data = 1'h0;
      #1.3;
      forever begin
         #32;
         o_bit_clk = i_run ? ~o_bit_clk : 1'h0;
      end
   end
   // one byte msb first; line shows the inverse afterwards, not a stale bit
   always @(posedge i_rd_go) begin
      for (int i = 7; i >= 0; i--) begin
         o_rd_data = i_rd_byte[i];
         #16 o_rd_clk = 1'h1;
         #16 o_rd_clk = 1'h0;
      end
      o_rd_data = ~o_rd_data;
   end
   // head takes a data bit on each write clock rise
   always @(posedge i_wr_clk) begin
      o_wr_byte <= {o_wr_byte[6:0], i_wr_data};
   end
endmodule : tape_head_model

// ===== tb/tape_write_read_serializer_test.sv
`timescale 1ns/1ps
`include "tape_serializer_regs.svh"
module tape_write_read_serializer_test;
   logic clk = 1'h0;
   logic rst_b = 1'h0;
   logic [3:0] addr = 4'h0;
   logic rd = 1'h0;
   logic wr = 1'h0;
   tape_serializer_pkg::word_t wdat = 32'h0;
   tape_serializer_pkg::word_t rdat, q;
   tape_serializer_pkg::byte_t wr_byte;
   logic waitreq, wclk, wdata, wave, strobe_b, irq_b, bit_clk, rd_clk, rd_data;
   logic run = 1'h0;
   logic rd_go = 1'h0;
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int wclk_n = 0;
   int n;
   // ------------------------------------------------------------
   // design, head model, clock
   // ------------------------------------------------------------
   tape_write_read_serializer #(.TIMER_CYCLES(50)) i_tape_write_read_serializer (
      .I_SYS_CLK(clk), .I_RST_B(rst_b), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
      .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(4'hF),
      .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(waitreq), .I_WRITE_BIT_CLOCK(bit_clk),
      .I_READ_CLOCK(rd_clk), .I_READ_DATA(rd_data), .O_WRITE_CLOCK(wclk),
      .O_WRITE_DATA(wdata), .O_WRITE_WAVEFORM(wave), .O_TIMER_STROBE_B(strobe_b),
      .O_IRQ_OUT_SECOND_B(irq_b));
   tape_head_model i_tape_head_model (.i_run(run), .i_rd_go(rd_go), .i_rd_byte(8'h96),
      .i_wr_clk(wclk), .i_wr_data(wdata), .o_bit_clk(bit_clk), .o_rd_clk(rd_clk),
      .o_rd_data(rd_data), .o_wr_byte(wr_byte));
   initial begin
      forever #2 clk = ~clk;
   end
   // cycle count doubles as the hang limit
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end
   always @(posedge wclk) wclk_n++;
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input tape_serializer_pkg::word_t exp,
         input tape_serializer_pkg::word_t got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // request held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [3:0] a, input tape_serializer_pkg::word_t d);
      addr <= a;
      wdat <= d;
      wr <= w;
      rd <= ~w;
      @(posedge clk);
      while (waitreq !== 1'h0) @(posedge clk);
      q = rdat;
      wr <= 1'h0;
      rd <= 1'h0;
      @(posedge clk);
   endtask : bus
   task automatic wait_irq();
      while (irq_b !== 1'h0) @(posedge clk);
   endtask : wait_irq
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      check("idle outputs", 32'h1, {wave, wclk, strobe_b, irq_b} == 4'h3);
      bus(1'h0, `STATUS_OFS, 32'h0);
      check("status", 32'h8, q);
   endtask : t_reset
   // read byte assembled; strobe must not reach write clock
   task automatic t_read();
      bus(1'h1, `CTRL_OFS, 32'h0);
      rd_go <= 1'h1;
      @(posedge clk);
      rd_go <= 1'h0;
      repeat (80) @(posedge clk);
      n = wclk_n;
      bus(1'h0, `READ_BYTE_OFS, 32'h0);
      check("read byte", 32'h96, q);
      repeat (40) @(posedge clk);
      check("write clocks", n, wclk_n);
   endtask : t_read
   // two bytes back to back, gate dropped during the second
   task automatic t_write();
      n = wclk_n;
      bus(1'h1, `WRITE_BYTE_OFS, 32'hA5);
      bus(1'h1, `CTRL_OFS, 32'hB);
      run <= 1'h1;
      wait_irq();
      check("byte one", 32'hA5, {24'h0, wr_byte});
      bus(1'h1, `WRITE_BYTE_OFS, 32'h3C);
      @(posedge clk);
      check("irq cleared", 32'h1, {31'h0, irq_b});
      // drop the gate only once the second cycle is under way
      while (wave !== 1'h1) @(posedge clk);
      bus(1'h1, `CTRL_OFS, 32'h9);
      wait_irq();
      check("byte two", 32'h3C, {24'h0, wr_byte});
      check("write clocks", n + 16, wclk_n);
      repeat (200) @(posedge clk);
      check("idle clocks", n + 16, wclk_n);
      check("idle wave", 32'h0, {31'h0, wave});
      run <= 1'h0;
   endtask : t_write
   // mark strobe gives one write clock, data low; then the timer runs out
   task automatic t_mark_timer();
      bus(1'h1, `CTRL_OFS, 32'h5);
      n = wclk_n;
      bus(1'h0, `READ_BYTE_OFS, 32'h0);
      repeat (30) @(posedge clk);
      check("mark clock", n + 1, wclk_n);
      check("mark data", 32'h0, {31'h0, wdata});
      bus(1'h0, `STATUS_OFS, 32'h0);
      check("timer busy", 32'h1, {31'h0, q[0]});
      n = cyc;
      while (q[0] !== 1'h0) bus(1'h0, `STATUS_OFS, 32'h0);
      check("timer span", 32'h1, (cyc - n) inside {[40:60]});
   endtask : t_mark_timer
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      t_reset();
      t_read();
      t_write();
      t_mark_timer();
      report_and_stop();
   end
endmodule : tape_write_read_serializer_test
